// file: alarm_pkg.sv
// shared constants for the input alarm monitor
package alarm_pkg;
   // alarm status bit positions
   localparam int ALM_W = 8;
   localparam int BIT_PATTERN = 0;
   localparam int BIT_PLL = 1;
   localparam int BIT_RPARITY = 2;
   localparam int BIT_FPARITY = 3;
   localparam int BIT_BLKPARITY = 4;
   localparam int BIT_COLLISION = 5;
   localparam int BIT_CONVCLK_GONE = 6;
   localparam int BIT_STROBE_GONE = 7;
   // shutoff configuration bit positions
   localparam int SHUT_W = 3;
   localparam int SHUT_CONVCLK = 0;
   localparam int SHUT_STROBE = 1;
   localparam int SHUT_COLLISION = 2;
   localparam logic [ALM_W-1:0] ALARM_RESET = 8'h00;
   localparam logic [ALM_W-1:0] MASK_RESET = 8'hFF;
   // clock-loss timeout: strobe bench period 160 ns, allow 2 us silence
   localparam int CLK_PERIOD_NS = 8;
   localparam int GONE_TIME_NS = 2000;
   localparam int GONE_CYCLES = GONE_TIME_NS / CLK_PERIOD_NS;
   localparam int GONE_CNT_W = 9;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
endpackage : alarm_pkg

// file: edge_watchdog.sv
// watchdog that reports when a sampled clock stops toggling
`timescale 1ns/1ps
module edge_watchdog
   import alarm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_edge,
   output logic o_gone
);
   logic [GONE_CNT_W-1:0] cnt_q, cnt_d;
   logic gone_d;

   always_comb begin
      cnt_d = cnt_q;
      gone_d = 1'b0;
      if (i_edge) begin
         cnt_d = '0;
      end else if (cnt_q != GONE_CNT_W'(GONE_CYCLES)) begin
         cnt_d = cnt_q + 1'b1;
      end
      if (cnt_q == GONE_CNT_W'(GONE_CYCLES)) begin
         gone_d = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0;
         o_gone <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         o_gone <= gone_d;
      end
   end
endmodule : edge_watchdog

// file: alarm_monitor.sv
// alarm monitor: sticky flags, mask, alarm pin and output shutoff
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - pattern mismatch while checking sets the pattern flag
// - pll losing lock sets the pll flag
// - rising-edge word plus parity bit failing check sets rising flag
// - falling-edge word plus parity bit failing check sets falling flag
// - block parity from frame marker mismatch sets block flag
// - enabled clock-loss or collision alarms force outputs off
// - mask register picks which alarms may drive the alarm pin
// - unmasked alarm raises pin; an enabled shutoff alarm shuts outputs even when masked
// - byte-wide format passes only the lower eight lanes to the data output
// - upper lanes in byte-wide format still feed the word parity, block parity and pattern checks
// - flags stay set until host clears them
// - equal fifo pointers raise the collision flag
// - word parity counts ones of sixteen lanes plus parity input
// - separate flags for conversion and strobe clock loss
// ----------------------------------------------------------------
module alarm_monitor
   import alarm_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_STROBE_CLK,
   input wire logic I_CONV_CLK,
   input wire logic [alarm_pkg::DATA_W-1:0] I_DATA,
   input wire logic I_PARITY,
   input wire logic I_FRAME,
   input wire logic I_PLL_LOCKED,
   input wire logic [2:0] I_WR_PTR,
   input wire logic [2:0] I_RD_PTR,
   input wire logic [alarm_pkg::DATA_W-1:0] I_PATTERN_KEY,
   input wire logic I_PATTERN_ENA,
   input wire logic I_WORD_PARITY_ENA,
   input wire logic I_FRAME_PARITY_ENA,
   input wire logic I_ODD_PARITY,
   input wire logic I_BYTE_WIDE,
   input wire logic [alarm_pkg::ALM_W-1:0] I_ALARM_MASK,
   input wire logic [alarm_pkg::SHUT_W-1:0] I_SHUTOFF_CFG,
   input wire logic [alarm_pkg::ALM_W-1:0] I_ALARM_CLEAR,
   input wire logic I_TX_GATE_PIN,
   input wire logic I_TX_GATE_BIT,
   output logic [alarm_pkg::ALM_W-1:0] O_ALARM_STATUS,
   output logic O_EVENT,
   output logic O_TX_ENABLE,
   output logic [alarm_pkg::DATA_W-1:0] O_RX_DATA
);
   import alarm_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = DATA_W + 7;
   logic [NSYNC-1:0] s1_q, s2_q, s1_d;
   logic [NSYNC-1:0] s2_d;
   logic strb_prev_q, strb_prev_d;
   logic conv_prev_q, conv_prev_d;

   always_comb begin
      s1_d = {I_STROBE_CLK, I_CONV_CLK, I_PARITY, I_FRAME, I_PLL_LOCKED,
              (I_WR_PTR == I_RD_PTR), 1'b0, I_DATA};
      s2_d = s1_q;
      strb_prev_d = s2_q[NSYNC-1];
      conv_prev_d = s2_q[NSYNC-2];
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         s1_q <= '0;
         s2_q <= '0;
         strb_prev_q <= 1'b0;
         conv_prev_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         strb_prev_q <= strb_prev_d;
         conv_prev_q <= conv_prev_d;
      end
   end

   logic strobe, conv, par_in, frame, locked, ptr_eq;
   logic [DATA_W-1:0] data_raw;
   assign strobe = s2_q[NSYNC-1];
   assign conv = s2_q[NSYNC-2];
   assign par_in = s2_q[NSYNC-3];
   assign frame = s2_q[NSYNC-4];
   assign locked = s2_q[NSYNC-5];
   assign ptr_eq = s2_q[NSYNC-6];
   assign data_raw = s2_q[DATA_W-1:0];

   logic strb_rise, strb_fall, conv_edge;
   assign strb_rise = strobe & ~strb_prev_q;
   assign strb_fall = ~strobe & strb_prev_q;
   assign conv_edge = conv ^ conv_prev_q;

   // ----------------------------------------------------------------
   // lane selection and parity
   // ----------------------------------------------------------------
   function automatic logic word_odd(input logic [DATA_W-1:0] w,
                                     input logic p);
      word_odd = ^{w, p};
   endfunction : word_odd

   // upper lanes dropped for the data path in byte-wide format
   logic [DATA_W-1:0] data_used;
   always_comb begin
      data_used = data_raw;
      if (I_BYTE_WIDE) begin
         data_used = {{BYTE_W{1'b0}}, data_raw[BYTE_W-1:0]};
      end
   end

   // checks see all 17 lines; source keeps unused lanes fixed
   logic word_bad;
   assign word_bad = word_odd(data_raw, par_in) != I_ODD_PARITY;

   // ----------------------------------------------------------------
   // block parity on frame marker
   // ----------------------------------------------------------------
   logic blk_acc_q, blk_acc_d;
   logic blk_wait_q, blk_wait_d;
   logic blk_done_q, blk_done_d;
   logic frame_prev_q, frame_prev_d;
   logic blk_err;

   always_comb begin
      blk_acc_d = blk_acc_q;
      blk_wait_d = blk_wait_q;
      blk_done_d = blk_done_q;
      frame_prev_d = frame_prev_q;
      blk_err = 1'b0;
      if (strb_rise) begin
         frame_prev_d = frame;
         if (frame & ~frame_prev_q) begin
            // block ends here; its parity arrives on the next fall
            blk_done_d = blk_acc_q ^ (^data_raw);
            blk_acc_d = 1'b0;
            blk_wait_d = 1'b1;
         end else begin
            blk_acc_d = blk_acc_q ^ (^data_raw);
         end
      end else if (strb_fall) begin
         blk_acc_d = blk_acc_q ^ (^data_raw);
         if (blk_wait_q) begin
            blk_wait_d = 1'b0;
            blk_err = frame != blk_done_q;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         blk_acc_q <= 1'b0;
         blk_wait_q <= 1'b0;
         blk_done_q <= 1'b0;
         frame_prev_q <= 1'b0;
      end else begin
         blk_acc_q <= blk_acc_d;
         blk_wait_q <= blk_wait_d;
         blk_done_q <= blk_done_d;
         frame_prev_q <= frame_prev_d;
      end
   end

   // ----------------------------------------------------------------
   // clock-loss watchdogs
   // ----------------------------------------------------------------
   logic strobe_gone, conv_gone;

   edge_watchdog u_strobe_wd (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_edge(strb_rise | strb_fall),
      .o_gone(strobe_gone)
   );

   edge_watchdog u_conv_wd (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_edge(conv_edge),
      .o_gone(conv_gone)
   );

   // ----------------------------------------------------------------
   // sticky alarm flags
   // ----------------------------------------------------------------
   logic [ALM_W-1:0] ev, alarm_q, alarm_d;
   logic [DATA_W-1:0] rx_q, rx_d;
   logic event_d, txen_d, kill;

   always_comb begin
      ev = '0;
      ev[BIT_PATTERN] = I_PATTERN_ENA & (strb_rise | strb_fall)
                        & (data_raw != I_PATTERN_KEY);
      ev[BIT_PLL] = ~locked;
      ev[BIT_RPARITY] = I_WORD_PARITY_ENA & strb_rise & word_bad;
      ev[BIT_FPARITY] = I_WORD_PARITY_ENA & strb_fall & word_bad;
      ev[BIT_BLKPARITY] = I_FRAME_PARITY_ENA & blk_err;
      ev[BIT_COLLISION] = ptr_eq;
      ev[BIT_CONVCLK_GONE] = conv_gone;
      ev[BIT_STROBE_GONE] = strobe_gone;
      // set wins over a clear in the same cycle
      alarm_d = (alarm_q & ~I_ALARM_CLEAR) | ev;
      event_d = |(alarm_d & ~I_ALARM_MASK);
      kill = (I_SHUTOFF_CFG[SHUT_CONVCLK] & alarm_d[BIT_CONVCLK_GONE])
           | (I_SHUTOFF_CFG[SHUT_STROBE] & alarm_d[BIT_STROBE_GONE])
           | (I_SHUTOFF_CFG[SHUT_COLLISION] & alarm_d[BIT_COLLISION]);
      txen_d = I_TX_GATE_PIN & I_TX_GATE_BIT & ~kill;
      rx_d = rx_q;
      if (strb_rise | strb_fall) begin
         rx_d = data_used;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         alarm_q <= ALARM_RESET;
         O_EVENT <= 1'b0;
         O_TX_ENABLE <= 1'b0;
         rx_q <= '0;
      end else begin
         alarm_q <= alarm_d;
         O_EVENT <= event_d;
         O_TX_ENABLE <= txen_d;
         rx_q <= rx_d;
      end
   end

   assign O_ALARM_STATUS = alarm_q;
   assign O_RX_DATA = rx_q;
endmodule : alarm_monitor

// file: alarm_monitor_properties.sv
// port checker for the input alarm monitor
`timescale 1ns/1ps
module alarm_monitor_chk
   import alarm_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_STROBE_CLK,
   input wire logic I_PLL_LOCKED,
   input wire logic [2:0] I_WR_PTR,
   input wire logic [2:0] I_RD_PTR,
   input wire logic I_BYTE_WIDE,
   input wire logic [alarm_pkg::ALM_W-1:0] I_ALARM_MASK,
   input wire logic [alarm_pkg::SHUT_W-1:0] I_SHUTOFF_CFG,
   input wire logic [alarm_pkg::ALM_W-1:0] I_ALARM_CLEAR,
   input wire logic [alarm_pkg::ALM_W-1:0] O_ALARM_STATUS,
   input wire logic O_EVENT,
   input wire logic O_TX_ENABLE,
   input wire logic [alarm_pkg::DATA_W-1:0] O_RX_DATA
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   logic strb_q;
   int quiet_q;
   // counts raw pin silence; slack of 10 covers sync and detect lag
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         strb_q <= 1'b0;
         quiet_q <= 0;
      end else begin
         strb_q <= I_STROBE_CLK;
         quiet_q <= (strb_q != I_STROBE_CLK) ? 0 : quiet_q + 1;
      end
   end
   // ----
   // assertions
   // ----
   a_event_or: assert property (
      O_EVENT == |(O_ALARM_STATUS & ~$past(I_ALARM_MASK)))
      else $error("alarm pin not or of unmasked flags");
   a_flag_sticky: assert property (
      ($past(O_ALARM_STATUS) & ~$past(I_ALARM_CLEAR) & ~O_ALARM_STATUS)
      == 8'h00) else $error("flag dropped without clear");
   a_pll_flag: assert property (
      !I_PLL_LOCKED [*3] |=> O_ALARM_STATUS[BIT_PLL])
      else $error("pll flag missing");
   a_collision_flag: assert property (
      (I_WR_PTR == I_RD_PTR) [*3] |=> O_ALARM_STATUS[BIT_COLLISION])
      else $error("collision flag missing");
   a_shut_collision: assert property (
      O_TX_ENABLE |-> !(O_ALARM_STATUS[BIT_COLLISION]
      && $past(I_SHUTOFF_CFG[SHUT_COLLISION])))
      else $error("output on after collision");
   a_shut_clock: assert property (
      O_TX_ENABLE |-> !(O_ALARM_STATUS[BIT_CONVCLK_GONE]
      && $past(I_SHUTOFF_CFG[SHUT_CONVCLK])) && !(O_ALARM_STATUS[
      BIT_STROBE_GONE] && $past(I_SHUTOFF_CFG[SHUT_STROBE])))
      else $error("output on after clock loss");
   a_byte_upper: assert property (
      $changed(O_RX_DATA) && I_BYTE_WIDE && $past(I_BYTE_WIDE, 8)
      |-> O_RX_DATA[15:8] == 8'h00) else $error("upper lanes used");
   a_strobe_gone: assert property (
      quiet_q == GONE_CYCLES + 10 |-> O_ALARM_STATUS[BIT_STROBE_GONE])
      else $error("strobe loss flag missing");
endmodule : alarm_monitor_chk
bind alarm_monitor alarm_monitor_chk i_chk (.I_CLK(I_CLK),
   .I_RSTN(I_RSTN), .I_STROBE_CLK(I_STROBE_CLK),
   .I_PLL_LOCKED(I_PLL_LOCKED), .I_WR_PTR(I_WR_PTR),
   .I_RD_PTR(I_RD_PTR), .I_BYTE_WIDE(I_BYTE_WIDE),
   .I_ALARM_MASK(I_ALARM_MASK), .I_SHUTOFF_CFG(I_SHUTOFF_CFG),
   .I_ALARM_CLEAR(I_ALARM_CLEAR), .O_ALARM_STATUS(O_ALARM_STATUS),
   .O_EVENT(O_EVENT), .O_TX_ENABLE(O_TX_ENABLE), .O_RX_DATA(O_RX_DATA));

// file: data_source.sv
// data source model: strobe clock, data lanes and word parity
`timescale 1ns/1ps
module data_source (
   input wire logic i_run,
   input wire logic i_odd,
   input wire logic i_bad,
   input wire logic i_blk,
   input wire logic i_byte,
   output logic o_strobe = 1'b0,
   output logic [15:0] o_data = 16'h0000,
   output logic o_parity = 1'b0,
   output logic o_frame = 1'b0
);
   int seed = 32'h220a7fef;
   int words = 0;
   logic acc = 1'b0;
   logic blk = 1'b0;
   logic pend = 1'b0;
   // strobe stands still when stopped; lanes keep changing
   always begin
      #40;
      if (i_run) begin
         o_data = 16'($random(seed));
         if (i_byte) begin
            o_data[15:8] = 8'hFF;
         end
         o_parity = ^o_data ^ i_odd ^ i_bad;
         // a block ends on a rising-edge word; its parity follows on the fall
         if (!o_strobe) begin
            words = words + 1;
            o_frame = i_blk && (words % 4 == 0);
            if (o_frame) begin
               blk = acc ^ (^o_data);
               acc = 1'b0;
               pend = 1'b1;
            end else begin
               acc = acc ^ (^o_data);
            end
         end else begin
            o_frame = pend & (blk ^ i_bad);
            acc = acc ^ (^o_data);
            pend = 1'b0;
         end
      end else begin
         o_data = ~o_data;
         o_parity = ~o_parity;
      end
      #40;
      if (i_run) o_strobe = ~o_strobe;
   end
endmodule : data_source

// file: tb_alarm_monitor.sv
// self-checking bench for the input alarm monitor
`timescale 1ns/1ps
module tb_alarm_monitor;
   import alarm_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, conv = 1'b0, conv_run = 1'b1;
   logic run = 1'b1, odd = 1'b0, bad = 1'b0, pll = 1'b1, bw = 1'b0;
   logic pat = 1'b0, wpar = 1'b0, want = 1'b0, strb, par, ev, tx;
   logic fpar = 1'b0, gpin = 1'b1, gbit = 1'b1, rx_want = 1'b0, frm;
   logic [15:0] data, rx;
   logic [15:0] rxe_q[$];
   logic [2:0] wr = 3'h0, rd = 3'h4, cfg = 3'h0;
   logic [7:0] mask = 8'hFF, clr = 8'h00, st;
   logic [9:0] exp_q[$];
   int mismatches = 0, tests_run = 0;
   always #4 clk = ~clk;
   // non-blocking so a toggle on a sampling edge is seen one edge later
   always #12 if (conv_run) conv <= ~conv;
   data_source i_src (.i_run(run), .i_odd(odd), .i_bad(bad),
      .i_blk(fpar), .i_byte(bw), .o_strobe(strb), .o_data(data),
      .o_parity(par), .o_frame(frm));
   alarm_monitor i_dut (
      .I_CLK(clk), .I_RSTN(rstn), .I_STROBE_CLK(strb), .I_CONV_CLK(conv),
      .I_DATA(data), .I_PARITY(par), .I_FRAME(frm), .I_PLL_LOCKED(pll),
      .I_WR_PTR(wr), .I_RD_PTR(rd), .I_PATTERN_KEY(16'h0000),
      .I_PATTERN_ENA(pat), .I_WORD_PARITY_ENA(wpar),
      .I_FRAME_PARITY_ENA(fpar), .I_ODD_PARITY(odd), .I_BYTE_WIDE(bw),
      .I_ALARM_MASK(mask), .I_SHUTOFF_CFG(cfg), .I_ALARM_CLEAR(clr),
      .I_TX_GATE_PIN(gpin), .I_TX_GATE_BIT(gbit), .O_ALARM_STATUS(st),
      .O_EVENT(ev), .O_TX_ENABLE(tx), .O_RX_DATA(rx));
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic cmp(input logic [9:0] e, input logic [9:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   task automatic cmp_rx(input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_rx
   // word is stable around the strobe edge; look after capture settles
   task automatic chk_rx();
      @(strb);
      rxe_q.push_back(bw ? {8'h00, data[7:0]} : data);
      wt(6);
      rx_want <= 1'b1;
      wt(1);
      rx_want <= 1'b0;
   endtask : chk_rx
   // expected value is {event, output enable, flags}
   task automatic chk(input logic [9:0] e);
      exp_q.push_back(e);
      want <= 1'b1;
      wt(1);
      want <= 1'b0;
   endtask : chk
   task automatic clear_all();
      clr <= 8'hFF;
      wt(1);
      clr <= 8'h00;
      wt(3);
   endtask : clear_all
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   always @(negedge clk) if (want) cmp(exp_q.pop_front(), {ev, tx, st});
   always @(negedge clk) if (rx_want) cmp_rx(rxe_q.pop_front(), rx);
   // ----
   // tests
   // ----
   initial begin
      wt(8);
      rstn <= 1'b1;
      wt(10);
      clear_all();
      chk(10'h100);
      pll <= 1'b0;
      wt(4);
      pll <= 1'b1;
      wt(10);
      chk(10'h102);
      mask <= 8'hFD;
      wt(3);
      chk(10'h302);
      clear_all();
      chk(10'h100);
      $display("pll test done");
      for (int o = 0; o < 2; o++) begin
         odd <= 1'(o);
         wpar <= 1'b1;
         wt(60);
         clear_all();
         wt(40);
         chk(10'h100);
         bad <= 1'b1;
         wt(60);
         bad <= 1'b0;
         wt(5);
         chk(10'h10C);
      end
      wpar <= 1'b0;
      clear_all();
      $display("parity test done");
      fpar <= 1'b1;
      wt(120);
      clear_all();
      wt(200);
      chk(10'h100);
      bad <= 1'b1;
      wt(100);
      bad <= 1'b0;
      wt(5);
      chk(10'h110);
      fpar <= 1'b0;
      clear_all();
      $display("block parity test done");
      pat <= 1'b1;
      wt(40);
      pat <= 1'b0;
      wt(6);
      chk(10'h101);
      clear_all();
      $display("pattern test done");
      cfg <= 3'h4;
      mask <= 8'hDF;
      wr <= 3'h4;
      wt(4);
      wr <= 3'h0;
      wt(6);
      chk(10'h220);
      clear_all();
      chk(10'h100);
      $display("collision test done");
      gpin <= 1'b0;
      wt(4);
      chk(10'h000);
      gpin <= 1'b1;
      gbit <= 1'b0;
      wt(4);
      chk(10'h000);
      gbit <= 1'b1;
      wt(4);
      $display("gate test done");
      cfg <= 3'h3;
      mask <= 8'hFF;
      run <= 1'b0;
      conv_run <= 1'b0;
      wt(300);
      chk(10'h0C0);
      run <= 1'b1;
      conv_run <= 1'b1;
      wt(20);
      clear_all();
      chk(10'h100);
      $display("clock loss test done");
      chk_rx();
      bw <= 1'b1;
      wpar <= 1'b1;
      wt(100);
      clear_all();
      wt(40);
      chk(10'h100);
      chk_rx();
      wpar <= 1'b0;
      $display("byte-wide test done");
      end_of_test();
   end
   initial begin
      #50000;
      mismatches++;
      end_of_test();
   end
endmodule : tb_alarm_monitor
